// >>> src/frame_buffer_retransmit.sv
/*
  Frame buffer control: circular image store, retransmit buffer, source selection
  and the control/status register on an Avalon-MM slave.
  Assumes images of a fixed word count arrive back to back on the acquisition stream
  and that shot strobes come from the acquisition control logic.
*/
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module frame_buffer_retransmit (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [fb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [fb_pkg::BUS_W-1:0] avs_writedata_i,
  input wire logic [fb_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [fb_pkg::BUS_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic iso_en_i,
  input wire logic format_change_i,
  input wire logic [fb_pkg::LEN_W-1:0] image_words_i,
  input wire logic one_shot_i,
  input wire logic multi_shot_i,
  input wire logic [fb_pkg::CNT_W-1:0] shot_count_i,
  input wire logic acq_valid_i,
  input wire logic [fb_pkg::DATA_W-1:0] acq_data_i,
  output logic acq_ready_o,
  output logic tx_valid_o,
  output logic [fb_pkg::DATA_W-1:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i
);
  logic rst_meta;
  logic rst_n;
  logic bus_done;
  logic img_buf_en;
  logic src_sel;
  logic pend_init;
  logic [fb_pkg::LEN_W-1:0] prev_words;
  logic [fb_pkg::LEN_W-1:0] len;
  logic [fb_pkg::CAP_W-1:0] cap;
  logic [fb_pkg::CAP_W-1:0] fill;
  logic [fb_pkg::SLOT_W-1:0] head;
  logic [fb_pkg::SLOT_W-1:0] slot;
  logic [fb_pkg::LEN_W-1:0] ofs;
  logic [fb_pkg::CNT_W-1:0] remaining;
  logic [fb_pkg::CNT_W-1:0] pend_count;
  logic pend_one;
  logic pend_multi;
  logic live_img;
  logic store_ok;
  fb_pkg::eng_state_e state;
  fb_pkg::eng_state_e next_state;
  logic [fb_pkg::CAP_W-1:0] next_fill;
  logic [fb_pkg::SLOT_W-1:0] next_head;
  logic [fb_pkg::SLOT_W-1:0] next_slot;
  logic [fb_pkg::LEN_W-1:0] next_ofs;
  logic [fb_pkg::CNT_W-1:0] next_remaining;
  logic [fb_pkg::CNT_W-1:0] next_pend_count;
  logic next_pend_one;
  logic next_pend_multi;
  logic next_live_img;
  logic next_store_ok;
  logic [fb_pkg::DATA_W-1:0] store_mem [fb_pkg::STORE_WORDS];
  logic [fb_pkg::DATA_W-1:0] retx_mem [fb_pkg::RETX_WORDS];
  logic buf_in_ready;
  logic [fb_pkg::WORD_W-1:0] tx_word;

  // Reset release through two flops; only the second is used anywhere
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register slave: one wait cycle, then the answer
  wire bus_req = avs_read_i | avs_write_i;
  wire hit = avs_address_i == fb_pkg::CTRL_ADDR;
  wire wr_fire = avs_write_i & bus_done & hit;
  wire ctrl_wr = wr_fire & avs_byteenable_i[fb_pkg::EN_BIT];
  wire init_req = ctrl_wr & avs_writedata_i[fb_pkg::EN_BIT];
  wire fmt_changed = format_change_i | (image_words_i != prev_words);
  wire apply_init = pend_init & (state != fb_pkg::ST_MULTI);
  wire [fb_pkg::LEN_W-1:0] eff_len = fb_pkg::clamp_len(image_words_i);
  wire [fb_pkg::CNT_W-1:0] cap_field = {{(fb_pkg::CNT_W-fb_pkg::CAP_W){1'b0}}, cap};
  wire [fb_pkg::CNT_W-1:0] fill_field = {{(fb_pkg::CNT_W-fb_pkg::CAP_W){1'b0}}, fill};
  // Capacity sits at bits 8..19, fill level above it, reserved bits read zero
  wire [fb_pkg::BUS_W-1:0] status_word = {fill_field, cap_field, {fb_pkg::RSVD_W{1'b0}}, src_sel, img_buf_en};
  assign avs_waitrequest_o = bus_req & ~bus_done;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_done <= 1'b0;
      avs_readdata_o <= '0;
    end
    else
    begin
      bus_done <= bus_req & ~bus_done;
      if (avs_read_i && !bus_done)
      begin
        avs_readdata_o <= hit ? status_word : '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      img_buf_en <= fb_pkg::EN_RESET;
      src_sel <= fb_pkg::SRC_RESET;
    end
    else if (ctrl_wr)
    begin
      img_buf_en <= avs_writedata_i[fb_pkg::EN_BIT];
      src_sel <= avs_writedata_i[fb_pkg::SRC_BIT];
    end
  end

  // Init is held pending through a multi-shot image so no frame is cut short
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_init <= 1'b1;
      prev_words <= '0;
      len <= fb_pkg::LEN_ONE;
      cap <= fb_pkg::FILL_ONE;
    end
    else
    begin
      prev_words <= image_words_i;
      pend_init <= (pend_init & ~apply_init) | init_req | fmt_changed;
      if (apply_init)
      begin
        len <= eff_len;
        cap <= fb_pkg::cap_of(eff_len);
      end
    end
  end

  // Live path unless buffered source chosen and continuous transmit is off
  wire buffered_ok = ~iso_en_i & src_sel;
  wire last_ofs = ofs >= len - fb_pkg::LEN_ONE;
  wire store_full = fill == cap;
  wire [fb_pkg::SLOT_W-1:0] tail_slot = fb_pkg::wrap_slot(head, fill, cap);
  wire [fb_pkg::SLOT_W-1:0] start_slot = store_full ? head : tail_slot;
  wire [fb_pkg::SLOT_W-1:0] head_inc = fb_pkg::wrap_slot(head, fb_pkg::FILL_ONE, cap);
  wire [fb_pkg::SLOT_W-1:0] wr_addr = fb_pkg::store_addr(slot, len, ofs);
  wire [fb_pkg::SLOT_W-1:0] rd_addr = fb_pkg::store_addr(head, len, ofs);
  wire [fb_pkg::RETX_AW-1:0] retx_addr = ofs[fb_pkg::RETX_AW-1:0];
  wire in_acq = state == fb_pkg::ST_ACQ;
  wire in_retx = state == fb_pkg::ST_RETX;
  wire in_multi = state == fb_pkg::ST_MULTI;
  wire [fb_pkg::DATA_W-1:0] buf_data = in_acq ? acq_data_i : (in_retx ? retx_mem[retx_addr] : store_mem[rd_addr]);
  wire buf_in_valid = (in_acq & live_img & acq_valid_i) | in_retx | in_multi;
  wire push = buf_in_valid & buf_in_ready;
  // Buffered-mode acquisition is stored only, so it never waits on the receiver
  assign acq_ready_o = in_acq & (~live_img | buf_in_ready);
  wire acq_take = acq_valid_i & acq_ready_o;
  wire commit = store_ok & img_buf_en & ~apply_init;

  // Retransmit buffer is never cleared: after a format change its content is stale
  always_ff @(posedge clk_i)
  begin
    if (in_acq && acq_take && store_ok && img_buf_en)
    begin
      store_mem[wr_addr] <= acq_data_i;
    end
    if ((in_acq && acq_take && live_img) || (in_multi && push))
    begin
      retx_mem[retx_addr] <= buf_data;
    end
  end

  always_comb
  begin
    next_state = state;
    next_fill = fill;
    next_head = head;
    next_slot = slot;
    next_ofs = ofs;
    next_remaining = remaining;
    next_live_img = live_img;
    next_store_ok = store_ok;
    next_pend_one = pend_one | (one_shot_i & buffered_ok);
    next_pend_multi = pend_multi | (multi_shot_i & buffered_ok);
    next_pend_count = pend_count;
    if (multi_shot_i && buffered_ok)
    begin
      next_pend_count = (shot_count_i == '0) ? fb_pkg::COUNT_ONE : shot_count_i;
    end
    if (apply_init)
    begin
      next_head = '0;
      next_fill = '0;
      next_store_ok = 1'b0;
    end
    case (state)
      fb_pkg::ST_IDLE:
      begin
        if (pend_init)
        begin
          next_state = fb_pkg::ST_IDLE;
        end
        else if (pend_multi)
        begin
          next_pend_multi = multi_shot_i & buffered_ok;
          next_remaining = pend_count;
          next_ofs = '0;
          if (fill != '0)
          begin
            next_state = fb_pkg::ST_MULTI;
          end
        end
        else if (pend_one)
        begin
          next_pend_one = one_shot_i & buffered_ok;
          next_ofs = '0;
          next_state = fb_pkg::ST_RETX;
        end
        else if (acq_valid_i)
        begin
          next_state = fb_pkg::ST_ACQ;
          next_ofs = '0;
          next_live_img = ~buffered_ok;
          next_slot = start_slot;
          next_store_ok = img_buf_en;
        end
      end
      fb_pkg::ST_ACQ:
      begin
        next_store_ok = next_store_ok & img_buf_en;
        if (acq_take)
        begin
          next_ofs = ofs + fb_pkg::LEN_ONE;
          if (last_ofs)
          begin
            next_state = fb_pkg::ST_IDLE;
            next_ofs = '0;
            if (commit && store_full)
            begin
              next_head = head_inc;
            end
            else if (commit)
            begin
              next_fill = fill + fb_pkg::FILL_ONE;
            end
          end
        end
      end
      fb_pkg::ST_RETX:
      begin
        if (push)
        begin
          next_ofs = last_ofs ? '0 : ofs + fb_pkg::LEN_ONE;
          next_state = last_ofs ? fb_pkg::ST_IDLE : fb_pkg::ST_RETX;
        end
      end
      fb_pkg::ST_MULTI:
      begin
        if (push)
        begin
          next_ofs = ofs + fb_pkg::LEN_ONE;
          if (last_ofs)
          begin
            next_ofs = '0;
            next_head = head_inc;
            next_fill = fill - fb_pkg::FILL_ONE;
            next_remaining = remaining - fb_pkg::COUNT_ONE;
            if (remaining == fb_pkg::COUNT_ONE || fill == fb_pkg::FILL_ONE || pend_init)
            begin
              next_state = fb_pkg::ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        next_state = fb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= fb_pkg::ST_IDLE;
      fill <= '0;
      head <= '0;
      slot <= '0;
      ofs <= '0;
      remaining <= '0;
      pend_count <= fb_pkg::COUNT_ONE;
      pend_one <= 1'b0;
      pend_multi <= 1'b0;
      live_img <= 1'b1;
      store_ok <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fill <= next_fill;
      head <= next_head;
      slot <= next_slot;
      ofs <= next_ofs;
      remaining <= next_remaining;
      pend_count <= next_pend_count;
      pend_one <= next_pend_one;
      pend_multi <= next_pend_multi;
      live_img <= next_live_img;
      store_ok <= next_store_ok;
    end
  end

  // A stalled receiver holds words here and back-pressures the engine
  pair_buffer #(
    .W(fb_pkg::WORD_W)
  ) u_tx_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(buf_in_valid),
    .in_data_i({last_ofs, buf_data}),
    .in_ready_o(buf_in_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_word),
    .out_ready_i(tx_ready_i)
  );

  assign tx_data_o = tx_word[fb_pkg::DATA_W-1:0];
  assign tx_last_o = tx_word[fb_pkg::LAST_BIT];
endmodule

// >>> src/fb_pkg.sv
/*
  Constants, state type and shared arithmetic for the frame buffer control block.
  Assumes a single 20 MHz clock and image words of sixteen bits.
*/
// Summary of operation
// - Buffered images are sent only while continuous acquisition is off.
// - With buffered source selected, one-shot and multi-shot send buffered images.
// - Multi-shot sends the requested count of stored images, at least one, but no more than the store holds.
// - One-shot with buffered source resends the last image in the retransmit buffer.
// - While buffering is on, every acquired image goes into the circular store.
// - When the store is full, a new image overwrites the oldest.
// - Every transmitted image, live or buffered, is copied to the retransmit buffer.
// - Without a previous image the retransmit buffer is still sent, content undefined.
// - Writing 1 to the buffer enable bit empties the store.
// - A format, mode, size or colour change empties the store and recomputes capacity.
// - Bit 0 switches buffering off or on; bits 2 to 7 are reserved.
// - Bit 1 selects live or buffered source; ignored while continuous transmit runs.
// - Bits 8 to 19 read the store capacity in images, always above zero.
// - A read-only field reports how many images the store holds.
package fb_pkg;
  localparam int ADDR_W = 12;
  localparam int BUS_W = 32;
  localparam int BE_W = 4;
  localparam int DATA_W = 16;
  localparam int WORD_W = 17;
  localparam int LEN_W = 7;
  localparam int SLOT_W = 8;
  localparam int CAP_W = 9;
  localparam int SUM_W = 10;
  localparam int PROD_W = 16;
  localparam int CNT_W = 12;
  localparam int RETX_AW = 6;
  localparam int RSVD_W = 6;
  localparam int STORE_WORDS = 256;
  localparam int RETX_WORDS = 64;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h634;
  localparam int EN_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int LAST_BIT = 16;
  localparam logic EN_RESET = 1'b0;
  localparam logic SRC_RESET = 1'b0;
  localparam logic [LEN_W-1:0] LEN_ONE = 7'h01;
  localparam logic [LEN_W-1:0] LEN_MAX = 7'h40;
  localparam logic [CNT_W-1:0] COUNT_ONE = 12'h001;
  localparam logic [CAP_W-1:0] FILL_ONE = 9'h001;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_RETX, ST_MULTI} eng_state_e;

  function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] len);
    logic [LEN_W-1:0] r;
    r = len;
    if (len == '0)
    begin
      r = LEN_ONE;
    end
    else if (len > LEN_MAX)
    begin
      r = LEN_MAX;
    end
    return r;
  endfunction

  function automatic logic [CAP_W-1:0] cap_of(input logic [LEN_W-1:0] len);
    int q;
    q = STORE_WORDS / int'(len);
    return q[CAP_W-1:0];
  endfunction

  function automatic logic [SLOT_W-1:0] wrap_slot(input logic [SLOT_W-1:0] base,
                                                  input logic [CAP_W-1:0] inc,
                                                  input logic [CAP_W-1:0] cap);
    logic [SUM_W-1:0] s;
    logic [SUM_W-1:0] r;
    s = {2'b00, base} + {1'b0, inc};
    r = (s >= {1'b0, cap}) ? s - {1'b0, cap} : s;
    return r[SLOT_W-1:0];
  endfunction

  function automatic logic [SLOT_W-1:0] store_addr(input logic [SLOT_W-1:0] slot,
                                                   input logic [LEN_W-1:0] len,
                                                   input logic [LEN_W-1:0] ofs);
    logic [PROD_W-1:0] p;
    p = {8'h00, slot} * {9'h000, len} + {9'h000, ofs};
    return p[SLOT_W-1:0];
  endfunction
endpackage

// >>> src/pair_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a reset already synchronised to clk_i.
*/
`timescale 1ns/100ps
module pair_buffer #(
  parameter int W = 17
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [1:0] fill;
  logic [W-1:0] second;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire one = fill == 2'h1;

  // Ready is combinational so a full pair stalls the source in the same cycle
  assign in_ready_o = fill != 2'h2;
  assign out_valid_o = fill != 2'h0;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fill <= 2'h0;
      out_data_o <= '0;
      second <= '0;
    end
    else if (push && pop)
    begin
      out_data_o <= one ? in_data_i : second;
      second <= in_data_i;
    end
    else if (push)
    begin
      fill <= fill + 2'h1;
      if (fill == 2'h0)
      begin
        out_data_o <= in_data_i;
      end
      else
      begin
        second <= in_data_i;
      end
    end
    else if (pop)
    begin
      fill <= fill - 2'h1;
      out_data_o <= second;
    end
  end
endmodule

// >>> sim/fbr_sva.sv
/*
  Checker for the frame buffer control block.
  Sees only top-level ports; bound to the block after the module.
*/
`timescale 1ns/100ps
module fbr_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [fb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [fb_pkg::BUS_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [fb_pkg::LEN_W-1:0] image_words_i,
  input wire logic tx_valid_o,
  input wire logic [fb_pkg::DATA_W-1:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i
);
  wire logic req = avs_read_i | avs_write_i;
  wire logic rd_done = avs_read_i & ~avs_waitrequest_o;
  wire logic rd_ctrl = rd_done & (avs_address_i == fb_pkg::CTRL_ADDR);
  wire logic [6:0] eff = (image_words_i == 7'h00) ? 7'h01 : (image_words_i > 7'h40) ? 7'h40 : image_words_i;
  wire logic [11:0] cap_exp = 12'h100 / {5'h00, eff};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_wait_one: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait not one cycle");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
  a_miss_zero: assert property (rd_done && avs_address_i != fb_pkg::CTRL_ADDR |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rsvd_zero: assert property (rd_ctrl |-> avs_readdata_o[7:2] == 6'h00)
    else $error("reserved bits set");
  a_cap_pos: assert property (rd_ctrl |-> avs_readdata_o[19:8] != 12'h000)
    else $error("capacity zero");
  a_cap_value: assert property (rd_ctrl && $past(image_words_i, 4) == image_words_i |-> avs_readdata_o[19:8] == cap_exp)
    else $error("capacity wrong");
  a_fill_max: assert property (rd_ctrl |-> avs_readdata_o[31:20] <= avs_readdata_o[19:8])
    else $error("fill above capacity");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("tx word lost on stall");
endmodule

bind frame_buffer_retransmit fbr_sva chk_u (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .image_words_i(image_words_i),
  .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o),
  .tx_last_o(tx_last_o),
  .tx_ready_i(tx_ready_i)
);

// >>> sim/tx_sink.sv
/*
  Host-side sink for the transmit stream: counts words and images.
  Assumes the block's valid/ready stream and an active-low reset.
*/
`timescale 1ns/100ps
module tx_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire logic [fb_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic [31:0] words_o,
  output logic [31:0] images_o,
  output logic [fb_pkg::DATA_W-1:0] first_o
);
  logic [1:0] ph;
  logic sof;
  // A stalling host takes one word in four, to fill the block's buffer
  assign tx_ready_o = ~stall_i | (ph == 2'h0);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ph <= 2'h0;
      sof <= 1'b1;
      words_o <= '0;
      images_o <= '0;
      first_o <= '0;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (tx_valid_i && tx_ready_o)
      begin
        words_o <= words_o + 32'h1;
        images_o <= images_o + {31'h0, tx_last_i};
        sof <= tx_last_i;
        if (sof)
          first_o <= tx_data_i;
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
/*
  Self-checking bench for the frame buffer control block.
  Assumes the tx_sink host model and the bound checker.
*/
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {logic [6:0] len; logic [11:0] cap;} row_s;
  localparam logic [11:0] CA = fb_pkg::CTRL_ADDR;
  row_s rows [6] = '{{7'h00, 12'h100}, {7'h01, 12'h100}, {7'h03, 12'h055}, {7'h08, 12'h020}, {7'h40, 12'h004},
    {7'h64, 12'h004}};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] avs_address_i = '0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic iso_en_i = 1'b0, format_change_i = 1'b0, one_shot_i = 1'b0, multi_shot_i = 1'b0;
  logic [6:0] image_words_i = 7'h40;
  logic [11:0] shot_count_i = '0;
  logic acq_valid_i = 1'b0;
  logic [15:0] acq_data_i = '0;
  logic acq_ready_o, tx_valid_o, tx_last_o, tx_ready_i, stall;
  logic [15:0] tx_data_o, first;
  logic [31:0] words, images, rd;
  int miscompares = 0;
  int compares = 0;

  always #25 clk_i = ~clk_i;

  frame_buffer_retransmit dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .iso_en_i(iso_en_i), .format_change_i(format_change_i), .image_words_i(image_words_i),
    .one_shot_i(one_shot_i), .multi_shot_i(multi_shot_i), .shot_count_i(shot_count_i),
    .acq_valid_i(acq_valid_i), .acq_data_i(acq_data_i), .acq_ready_o(acq_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));
  tx_sink sink_u (.clk_i(clk_i), .rst_n_i(arst_n_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .words_o(words),
    .images_o(images), .first_o(first));

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    miscompares++;
    $display("[ERR] %0t wait timed out", $time);
    print_verdict();
  endtask

  // Starts one edge late so a release is never overwritten in the same step
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50)
      hang();
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    format_change_i <= (k == 0);
    one_shot_i <= (k == 1);
    multi_shot_i <= (k == 2);
    @(posedge clk_i);
    {format_change_i, one_shot_i, multi_shot_i} <= 3'h0;
  endtask

  // Images of 64 words, each word tagged with image number and index
  task automatic acq(input logic [7:0] img);
    int i;
    int n;
    i = 0;
    n = 0;
    acq_valid_i <= 1'b1;
    acq_data_i <= {img, 8'h00};
    while (i < 64 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
      if (acq_ready_o === 1'b1)
      begin
        i++;
        acq_data_i <= {img, i[7:0]};
      end
    end
    acq_valid_i <= 1'b0;
    if (n >= 2000)
      hang();
    @(posedge clk_i);
  endtask

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (words !== n && k < 5000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(words, n);
  endtask

  initial
  begin
    stall = 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk(CA, 32'h0000_0400);
    foreach (rows[i])
    begin
      image_words_i <= rows[i].len;
      pulse(0);
      repeat (3) @(posedge clk_i);
      rchk(CA, {12'h000, rows[i].cap, 8'h00});
    end
    bus(1'b1, CA, 32'h2, 4'hf);
    pulse(1);
    wait_rx(64);
    chk(images, 32'h1);
    image_words_i <= 7'h40;
    bus(1'b1, CA, 32'h1, 4'hf);
    acq(8'h00);
    wait_rx(128);
    chk({16'h0, first}, 32'h0);
    rchk(CA, 32'h0010_0401);
    bus(1'b1, CA, 32'h3, 4'hf);
    for (int j = 1; j < 6; j++)
      acq(j[7:0]);
    chk(words, 32'd128);
    rchk(CA, 32'h0040_0403);
    stall <= 1'b1;
    shot_count_i <= 12'h002;
    pulse(2);
    wait_rx(256);
    chk({16'h0, first}, 32'h0300);
    rchk(CA, 32'h0020_0403);
    pulse(1);
    wait_rx(320);
    chk({16'h0, first}, 32'h0300);
    chk(images, 32'h5);
    iso_en_i <= 1'b1;
    pulse(1);
    pulse(2);
    repeat (300) @(posedge clk_i);
    chk(words, 32'd320);
    acq(8'h07);
    wait_rx(384);
    chk({16'h0, first}, 32'h0700);
    iso_en_i <= 1'b0;
    pulse(1);
    wait_rx(448);
    chk({16'h0, first}, 32'h0700);
    bus(1'b1, CA, 32'h0, 4'h0);
    rchk(CA, 32'h0030_0403);
    rchk(12'h630, 32'h0);
    bus(1'b1, CA, 32'hff, 4'hf);
    rchk(CA, 32'h0000_0403);
    acq(8'h06);
    rchk(CA, 32'h0010_0403);
    pulse(0);
    repeat (3) @(posedge clk_i);
    rchk(CA, 32'h0000_0403);
    pulse(2);
    repeat (300) @(posedge clk_i);
    chk(words, 32'd448);
    // Mid-run reset must bring the register and the host count back to idle
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk(CA, 32'h0000_0400);
    chk(words, 32'h0);
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clk_i);
    hang();
  end
endmodule
